// ==== hw/pcw_pkg.sv ====
/*
 * Package of the pin-change / wake interrupt flag block: register
 * addresses, field positions, reset values and port geometry.
 * Assumes a byte-wide special-function-register bus with 8-bit addresses.
 */
package pcw_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] PCW_ADDR_PORT_FLAGS = 8'h85;
    localparam logic [7:0] PCW_ADDR_PORT_IDX = 8'h91;
    localparam logic [7:0] PCW_ADDR_SHARED = 8'h95;
    localparam logic [7:0] PCW_ADDR_PIN_FLAGS = 8'h96;
    localparam logic [7:0] PCW_ADDR_SLAVE_CTL = 8'hEA;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PCW_SH_LVD = 7;
    localparam int PCW_SH_ADC = 4;
    localparam int PCW_SH_PC = 1;
    localparam int PCW_SH_TMR = 0;
    localparam int PCW_SC_EN_LSB = 4;
    localparam int PCW_SC_RX1_EN = 0;
    localparam int PCW_SC_RX2_EN = 1;
    localparam int PCW_SC_RX1_F = 0;
    localparam int PCW_SC_RX2_F = 1;
    localparam int PCW_SC_TX_F = 2;

    // ------------------------------------------------------------
    // reset values and special codes
    // ------------------------------------------------------------
    localparam logic [3:0] PCW_RST_PORT_FLAGS = 4'h0;
    localparam logic [1:0] PCW_RST_IDX = 2'h0;
    localparam logic [31:0] PCW_RST_PIN_FLAGS = 32'h0000_0000;
    localparam logic [3:0] PCW_RST_SC_EN = 4'h0;
    localparam logic [2:0] PCW_RST_SC_FLG = 3'h4;
    localparam logic [7:0] PCW_LVD_CLEAR_CODE = 8'h7F;

    // ------------------------------------------------------------
    // port geometry: four ports of eight, the third has six pins
    // ------------------------------------------------------------
    localparam int PCW_NPORT = 4;
    localparam int PCW_NPIN = 32;
    localparam int PCW_NSYNC = 34;
    localparam logic [31:0] PCW_PIN_MASK = 32'hFF3F_FFFF;
endpackage

// ==== hw/pcw_sync_if.sv ====
/*
 * Carrier between the pin synchroniser and the flag logic.
 * Assumes both ends run on the one system clock.
 */
`timescale 1ns/10ps
interface pcw_sync_if;
    logic [33:0] level;
    logic [33:0] change;
    logic [33:0] fall;
    modport src (output level, output change, output fall);
    modport dst (input level, input change, input fall);
endinterface

// ==== hw/pcw_pin_sync.sv ====
/*
 * Two-flop synchroniser and change detector for the port and
 * external-interrupt pins. Assumes pins idle high after reset.
 */
`timescale 1ns/10ps
module pcw_pin_sync
    import pcw_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [PCW_NSYNC-1:0] raw,
    pcw_sync_if.src sy
);
    typedef struct packed {
        logic [PCW_NSYNC-1:0] meta;
        logic [PCW_NSYNC-1:0] stable;
        logic [PCW_NSYNC-1:0] prev;
    } pcw_sync_t;

    pcw_sync_t s;
    pcw_sync_t next_s;

    // ------------------------------------------------------------
    // sampling chain: meta feeds stable and nothing else
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.meta = raw;
        next_s.stable = s.meta;
        next_s.prev = s.stable;
    end

    // reset to all ones so idle-high pins raise no false edge
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '1;
        end else begin
            s <= next_s;
        end
    end

    // compare current and previous samples
    assign sy.level = s.stable;
    assign sy.change = s.stable ^ s.prev;
    assign sy.fall = s.prev & ~s.stable;
endmodule // pcw_pin_sync

// ==== hw/pcw_top.sv ====
/*
 * Pin-change, external-pin and supply-low interrupt flags with
 * halt/stop wake-up and the slave serial control register.
 * Assumes the CPU reaches registers over the byte-wide SFR bus and the
 * pin-mode enables, pin-change enable and low-power state come as inputs.
 */
`timescale 1ns/10ps
module pcw_top
    import pcw_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic [31:0] port_pins,
    input wire logic ext_irq_pin_a,
    input wire logic ext_irq_pin_b,
    input wire logic [31:0] pin_chg_en,
    input wire logic [1:0] ext_irq_enable,
    input wire logic [1:0] ext_trig_edge,
    input wire logic pc_irq_en,
    input wire logic low_power,
    input wire logic lvd_trip,
    input wire logic adc_done,
    input wire logic timer_c_ovf,
    input wire logic slave_rx1_done,
    input wire logic slave_rx2_done,
    input wire logic slave_tx_done,
    output logic [1:0] ext_irq_req,
    output logic wake_req,
    output logic lp_entry_block,
    output logic pin_change_irq,
    output logic slave_rx1_irq,
    output logic slave_rx2_irq
);
    typedef struct packed {
        logic [1:0] idx;
        logic [3:0] port_flg;
        logic [31:0] pin_flg;
        logic supply_level_detector;
        logic adc;
        logic any_pin_change_flag;
        logic tmr;
        logic [3:0] sc_en;
        logic [2:0] sc_flg;
        logic [7:0] rdata;
        logic [1:0] ext_req;
        logic wake;
        logic lp_block;
        logic pc_irq;
        logic rx1_irq;
        logic rx2_irq;
    } pcw_state_t;

    pcw_state_t s;
    pcw_state_t next_s;
    pcw_sync_if sy ();
    logic [31:0] chg;
    logic [PCW_NPORT-1:0] port_hit;
    logic [1:0] ext_ev;

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    pcw_pin_sync u_sync (
        .clk(clk),
        .rst(rst),
        .raw({ext_irq_pin_b, ext_irq_pin_a, port_pins}),
        .sy(sy.src)
    );

    // enabled changes; upper two pins of the third port do not exist
    assign chg = sy.change[31:0] & pin_chg_en & PCW_PIN_MASK;

    // per-port summary of changes
    genvar p;
    generate
        for (p = 0; p < PCW_NPORT; p = p + 1) begin : g_port
            assign port_hit[p] = |chg[p*8 +: 8];
        end
    endgenerate

    // external pin events by trigger type, gated by their enable
    assign ext_ev = ext_irq_enable & ((ext_trig_edge & sy.fall[33:32])
                  | (~ext_trig_edge & ~sy.level[33:32]));

    // ------------------------------------------------------------
    // next state: writes first, hardware sets last so sets win
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        if (sfr_wr) begin
            case (sfr_addr)
                PCW_ADDR_PORT_FLAGS: begin
                    next_s.port_flg = s.port_flg & sfr_wdata[3:0];
                end
                PCW_ADDR_PORT_IDX: begin
                    next_s.idx = sfr_wdata[1:0];
                end
                PCW_ADDR_SHARED: begin
                    if (sfr_wdata == PCW_LVD_CLEAR_CODE) begin
                        next_s.supply_level_detector = 1'b0;
                    end
                    next_s.adc = s.adc & sfr_wdata[PCW_SH_ADC];
                    next_s.tmr = s.tmr & sfr_wdata[PCW_SH_TMR];
                    if (!sfr_wdata[PCW_SH_PC]) begin
                        next_s.any_pin_change_flag = 1'b0;
                        next_s.pin_flg = PCW_RST_PIN_FLAGS;
                        next_s.port_flg = PCW_RST_PORT_FLAGS;
                    end
                end
                PCW_ADDR_PIN_FLAGS: begin
                    next_s.pin_flg[{s.idx, 3'b000} +: 8] =
                        s.pin_flg[{s.idx, 3'b000} +: 8] & sfr_wdata;
                end
                PCW_ADDR_SLAVE_CTL: begin
                    next_s.sc_en = sfr_wdata[7:PCW_SC_EN_LSB];
                    next_s.sc_flg = sfr_wdata[2:0];
                end
                default: begin
                    next_s.idx = s.idx;
                end
            endcase
        end
        // hardware sets
        next_s.supply_level_detector = next_s.supply_level_detector | lvd_trip;
        next_s.adc = next_s.adc | adc_done;
        next_s.tmr = next_s.tmr | timer_c_ovf;
        next_s.sc_flg[PCW_SC_RX1_F] = next_s.sc_flg[PCW_SC_RX1_F] | slave_rx1_done;
        next_s.sc_flg[PCW_SC_RX2_F] = next_s.sc_flg[PCW_SC_RX2_F] | slave_rx2_done;
        next_s.sc_flg[PCW_SC_TX_F] = next_s.sc_flg[PCW_SC_TX_F] | slave_tx_done;
        // pin change only counts in halt/stop
        if (low_power) begin
            next_s.pin_flg = next_s.pin_flg | chg;
            next_s.port_flg = next_s.port_flg | port_hit;
            if (|port_hit && pc_irq_en) begin
                next_s.any_pin_change_flag = 1'b1;
            end
        end
        // outputs, registered
        next_s.ext_req = ext_ev;
        next_s.wake = low_power & ((|ext_ev) | (|port_hit));
        next_s.lp_block = |(ext_irq_enable & ~sy.level[33:32]);
        next_s.pc_irq = s.any_pin_change_flag;
        next_s.rx1_irq = s.sc_en[PCW_SC_RX1_EN] & s.sc_flg[PCW_SC_RX1_F];
        next_s.rx2_irq = s.sc_en[PCW_SC_RX2_EN] & s.sc_flg[PCW_SC_RX2_F];
        // read data; unmapped addresses read zero
        next_s.rdata = 8'h00;
        if (sfr_rd) begin
            case (sfr_addr)
                PCW_ADDR_PORT_FLAGS: next_s.rdata = {4'h0, s.port_flg};
                PCW_ADDR_PORT_IDX: next_s.rdata = {6'h00, s.idx};
                PCW_ADDR_SHARED: next_s.rdata = {s.supply_level_detector, 2'h0, s.adc, 2'h0, s.any_pin_change_flag, s.tmr};
                PCW_ADDR_PIN_FLAGS: next_s.rdata = s.pin_flg[{s.idx, 3'b000} +: 8];
                PCW_ADDR_SLAVE_CTL: next_s.rdata = {s.sc_en, 1'b0, s.sc_flg};
                default: next_s.rdata = 8'h00;
            endcase
        end
    end

    // state register; supply-low flag starts clear
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.idx <= PCW_RST_IDX;
            s.port_flg <= PCW_RST_PORT_FLAGS;
            s.pin_flg <= PCW_RST_PIN_FLAGS;
            s.sc_en <= PCW_RST_SC_EN;
            s.sc_flg <= PCW_RST_SC_FLG;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from the state register
    // ------------------------------------------------------------
    assign sfr_rdata = s.rdata;
    assign ext_irq_req = s.ext_req;
    assign wake_req = s.wake;
    assign lp_entry_block = s.lp_block;
    assign pin_change_irq = s.pc_irq;
    assign slave_rx1_irq = s.rx1_irq;
    assign slave_rx2_irq = s.rx2_irq;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic wr_sh;
    assign wr_sh = sfr_wr && sfr_addr == PCW_ADDR_SHARED;

    rx2_irq_gate_a: assert property (s.sc_en[1] && s.sc_flg[1] |=> slave_rx2_irq)
        else $error("rx2 irq not raised");
    rx1_irq_gate_a: assert property (!s.sc_en[0] |=> !slave_rx1_irq)
        else $error("rx1 irq without enable");
    ext_level_req_a: assert property (ext_irq_enable[0] && !ext_trig_edge[0]
        && !sy.level[32] |=> ext_irq_req[0])
        else $error("low level not requested");
    wake_on_change_a: assert property (low_power && |port_hit |=> wake_req)
        else $error("no wake on pin change");
    pin_flag_set_a: assert property (low_power && |chg
        |=> (s.pin_flg & $past(chg)) == $past(chg))
        else $error("pin flag not set");
    awake_no_change_a: assert property (!low_power && !sfr_wr
        |=> s.pin_flg == $past(s.pin_flg))
        else $error("pin flag moved outside low power");
    lp_entry_block_a: assert property (ext_irq_enable[1] && !sy.level[33]
        |=> lp_entry_block)
        else $error("low power not blocked");
    port_c_mask_a: assert property (s.pin_flg[23:22] == 2'b00)
        else $error("missing pins flagged");
    idx_write_a: assert property (sfr_wr && sfr_addr == PCW_ADDR_PORT_IDX
        |=> s.idx == $past(sfr_wdata[1:0]))
        else $error("index not written");
    lvd_set_a: assert property (lvd_trip |=> s.supply_level_detector)
        else $error("supply-low flag not set");
    lvd_clear_a: assert property (wr_sh && sfr_wdata == 8'h7F && !lvd_trip
        |=> !s.supply_level_detector)
        else $error("supply-low flag not cleared");
    any_pin_change_flag_set_a: assert property (low_power && |port_hit && pc_irq_en
        |=> s.any_pin_change_flag ##1 pin_change_irq)
        else $error("summary flag not set");
    any_pin_change_flag_clear_all_a: assert property (wr_sh && !sfr_wdata[1] && !(low_power && |chg)
        |=> s.pin_flg == 32'h0 && s.port_flg == 4'h0 && !s.any_pin_change_flag)
        else $error("change flags not cleared");
    write_one_keep_a: assert property (wr_sh && sfr_wdata[0] && s.tmr |=> s.tmr)
        else $error("write one cleared flag");
    txd_reset_a: assert property ($past(rst) |-> s.sc_flg == 3'b100)
        else $error("tx-done reset value wrong");

    wake_seen_c: cover property (low_power && |port_hit ##1 wake_req);
    lvd_cleared_c: cover property (s.supply_level_detector ##1 wr_sh && sfr_wdata == 8'h7F ##1 !s.supply_level_detector);
    ext_edge_c: cover property (ext_trig_edge[1] && ext_irq_req[1]);
endmodule // pcw_top

// ==== bench/pcw_pin_model.sv ====
/*
 * Far-side model of the port pins and the two external interrupt pins.
 * Assumes the bench calls its tasks; pins change only on a falling edge.
 */
`timescale 1ns/10ps
module pcw_pin_model (
    input wire logic clk,
    output logic [31:0] port_pins,
    output logic ext_a,
    output logic ext_b
);
    // ------------------------------------------------------------
    // pin levels: idle high so release from reset is quiet
    // ------------------------------------------------------------
    initial begin
        port_pins = 32'hFFFF_FFFF;
        ext_a = 1'b1;
        ext_b = 1'b1;
    end

    // flip one port pin, away from the sampling edge
    task automatic toggle(input int n);
        @(negedge clk);
        port_pins[n] = ~port_pins[n];
    endtask

    // drive both external pins to given levels
    task automatic set_ext(input logic a, input logic b);
        @(negedge clk);
        ext_a = a;
        ext_b = b;
    endtask
endmodule // pcw_pin_model

// ==== bench/testbench.sv ====
/*
 * Self-checking bench of pcw_top: register tasks, pin stimulus, checks.
 * Assumes pcw_pkg and the pin model are compiled first.
 */
`timescale 1ns/10ps
module testbench;
    import pcw_pkg::*;
    logic clk, rst, sfr_wr, sfr_rd, pc_en, low_power;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [31:0] port_pins, pin_chg_en;
    logic ext_a, ext_b, wake_req, lp_block, pc_irq, rx1_irq, rx2_irq;
    logic [1:0] ext_en, ext_edge, ext_req;
    logic [5:0] evt;
    int n_mismatch, check_count, n_wake, n_edge, w0, e0;

    pcw_pin_model u_pins (.clk(clk), .port_pins(port_pins), .ext_a(ext_a), .ext_b(ext_b));
    pcw_top u_dut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .port_pins(port_pins), .ext_irq_pin_a(ext_a), .ext_irq_pin_b(ext_b),
        .pin_chg_en(pin_chg_en), .ext_irq_enable(ext_en), .ext_trig_edge(ext_edge),
        .pc_irq_en(pc_en), .low_power(low_power), .lvd_trip(evt[0]), .adc_done(evt[1]),
        .timer_c_ovf(evt[2]), .slave_rx1_done(evt[3]), .slave_rx2_done(evt[4]),
        .slave_tx_done(evt[5]), .ext_irq_req(ext_req), .wake_req(wake_req),
        .lp_entry_block(lp_block), .pin_change_irq(pc_irq), .slave_rx1_irq(rx1_irq),
        .slave_rx2_irq(rx2_irq));

    // ------------------------------------------------------------
    // clock, event counters, watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // one-cycle pulses are counted so a missed or doubled pulse shows
    always @(posedge clk) begin
        if (wake_req === 1'b1) n_wake++;
        if (ext_req[0] === 1'b1) n_edge++;
        if (ext_req[1] === 1'b1) n_edge++;
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask

    // data stands only in the cycle after the read edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        chk(sfr_rdata, exp);
    endtask

    task automatic pulse(input logic [5:0] m);
        @(negedge clk);
        evt = m;
        @(negedge clk);
        evt = 6'h00;
    endtask

    // pin to flag takes about three cycles; eight leaves margin
    task automatic settle();
        repeat (8) @(negedge clk);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, evt} = '0;
        {ext_en, ext_edge, low_power, n_mismatch, check_count, n_wake, n_edge} = '0;
        pin_chg_en = 32'hFFFF_FEFF;
        pc_en = 1'b1;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        // reset values and an unmapped address
        rd(8'h85, 8'h00);
        rd(8'h91, 8'h00);
        rd(8'h96, 8'h00);
        rd(8'hEA, 8'h04);
        rd(8'h95, 8'h00);
        rd(8'h50, 8'h00);
        // no flags while running
        u_pins.toggle(0);
        settle();
        rd(8'h85, 8'h00);
        // disabled pin 8 and missing pin 23 of port c stay quiet
        low_power = 1'b1;
        u_pins.toggle(8);
        u_pins.toggle(23);
        settle();
        rd(8'h85, 8'h00);
        w0 = n_wake;
        u_pins.toggle(19);
        settle();
        chk(8'(n_wake - w0), 8'h01);
        rd(8'h85, 8'h04);
        wr(8'h91, 8'h02);
        rd(8'h91, 8'h02);
        rd(8'h96, 8'h08);
        rd(8'h95, 8'h02);
        chk({7'h00, pc_irq}, 8'h01);
        // writing ones keeps, zeros clear
        wr(8'h96, 8'hFF);
        rd(8'h96, 8'h08);
        wr(8'h96, 8'h00);
        rd(8'h96, 8'h00);
        rd(8'h85, 8'h04);
        wr(8'h85, 8'h0B);
        rd(8'h85, 8'h00);
        // summary clear sweeps every pin and port flag
        wr(8'h91, 8'h00);
        u_pins.toggle(0);
        u_pins.toggle(31);
        settle();
        rd(8'h96, 8'h01);
        rd(8'h85, 8'h09);
        wr(8'h95, 8'hFD);
        rd(8'h85, 8'h00);
        rd(8'h96, 8'h00);
        rd(8'h95, 8'h00);
        // summary needs its enable, port flag does not
        pc_en = 1'b0;
        u_pins.toggle(1);
        settle();
        rd(8'h85, 8'h01);
        rd(8'h95, 8'h00);
        pc_en = 1'b1;
        wr(8'h85, 8'h00);
        // supply-low, converter and timer flags
        pulse(6'h07);
        rd(8'h95, 8'h91);
        wr(8'h95, 8'hFF);
        rd(8'h95, 8'h91);
        wr(8'h95, 8'hEE);
        rd(8'h95, 8'h80);
        wr(8'h95, 8'h7F);
        rd(8'h95, 8'h00);
        // slave serial control: enables gate the receive interrupts
        wr(8'hEA, 8'h00);
        pulse(6'h08);
        rd(8'hEA, 8'h01);
        chk({7'h00, rx1_irq}, 8'h00);
        wr(8'hEA, 8'h31);
        settle();
        chk({6'h00, rx2_irq, rx1_irq}, 8'h01);
        pulse(6'h10);
        pulse(6'h20);
        rd(8'hEA, 8'h37);
        chk({7'h00, rx2_irq}, 8'h01);
        wr(8'hEA, 8'hC0);
        rd(8'hEA, 8'hC0);
        settle();
        chk({6'h00, rx2_irq, rx1_irq}, 8'h00);
        // external pins: level mode and low-power entry block
        low_power = 1'b0;
        ext_en = 2'b01;
        u_pins.set_ext(1'b0, 1'b1);
        settle();
        chk({5'h00, lp_block, ext_req}, 8'h05);
        u_pins.set_ext(1'b1, 1'b0);
        settle();
        chk({5'h00, lp_block, ext_req}, 8'h00);
        u_pins.set_ext(1'b1, 1'b1);
        // edge mode: one request per fall, and a wake in low power
        ext_edge = 2'b01;
        low_power = 1'b1;
        settle();
        e0 = n_edge;
        w0 = n_wake;
        u_pins.set_ext(1'b0, 1'b1);
        settle();
        chk(8'(n_edge - e0), 8'h01);
        chk({7'h00, n_wake != w0}, 8'h01);
        u_pins.set_ext(1'b1, 1'b1);
        settle();
        // pin b in edge mode; enables narrowed so a disabled pin stays quiet
        ext_en = 2'b10;
        ext_edge = 2'b10;
        pin_chg_en = 32'h0000_00FF;
        u_pins.toggle(9);
        settle();
        rd(8'h85, 8'h00);
        e0 = n_edge;
        w0 = n_wake;
        u_pins.set_ext(1'b1, 1'b0);
        settle();
        chk(8'(n_edge - e0), 8'h01);
        chk({7'h00, n_wake != w0}, 8'h01);
        chk({5'h00, lp_block, ext_req}, 8'h04);
        u_pins.set_ext(1'b1, 1'b1);
        settle();
        chk({5'h00, lp_block, ext_req}, 8'h00);
        pin_chg_en = 32'hFFFF_FFFF;
        stop_test();
    end
endmodule // testbench
